/* uvr_consts.svh */
// What this block does
// - Mode-control flags are active low
// - Undervoltage flag sets only after detection timer
// - Detected wake-up sets wake flag, steers modes
// - Error output shows wake flag, source or error
// - Error bit set by status bits 8-10
// - Error source follows host command, not mode
// - Receive outputs follow actual operating mode
// - Sleep cause flag gates enable in sleep
// - Normal entry first, then wake flag clears
// - Wake flag never set in normal mode
// - Mode change and its sleep cause flag update in the same cycle
// - Follow-bus: receive outputs track bus lines in normal and listen-only modes
// - Sleep recovery follows host command
// - Undervoltage sleep keeps enable; host sleep disables
// - Sleep cause flag stays internal
`ifndef UVR_CONSTS_SVH
`define UVR_CONSTS_SVH

// ==========================================================
// Timing
`define CLK_PERIOD_NS 10
`define UV_DETECT_US 100
`define UV_DETECT_CYCLES ((`UV_DETECT_US * 1000) / `CLK_PERIOD_NS)
`define UV_CNT_W 16

// ==========================================================
// Supply indices and status bit positions
`define SUPPLY_BAT 0
`define SUPPLY_IO 1
`define SUPPLY_CORE 2
`define STATUS_W 16
`define STATUS_BIT_BAT 8
`define STATUS_BIT_CORE 9
`define STATUS_BIT_IO 10

// ==========================================================
// Pin synchroniser slots
`define PIN_STBY_N 0
`define PIN_EN 1
`define PIN_BUS_DATA 2
`define PIN_BUS_ACT 3
`define PIN_NUM 4

// ==========================================================
// Reset values
`define FLAG_N_RST 1'h1
`define OUT_RST 1'h1
`define STATUS_RST 16'h0000

`endif

/* uvr_pkg.sv */
package uvr_pkg;
    typedef enum logic [2:0]
    {
        low_power_sleep_mode   = 3'h0,
        standby_low_power_mode = 3'h1,
        full_operation_mode    = 3'h3,
        listen_only_mode       = 3'h2,
        sleep_request_mode     = 3'h6
    } op_mode_e;
endpackage

/* uv_flag_if.sv */
`timescale 1ns/1ns
interface uv_flag_if;
    logic flag_n;
    logic restart;
    modport timer (output flag_n, input restart);
    modport fsm (input flag_n, output restart);
endinterface

/* uv_flag_timer.sv */
`timescale 1ns/1ns
`include "uvr_consts.svh"
module uv_flag_timer #(
    parameter int LIMIT = `UV_DETECT_CYCLES
)(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic supply_low,
    uv_flag_if.timer uv
);
    logic s1_q, s2_q, s3_q, low_q;
    logic [`UV_CNT_W-1:0] cnt_q;
    localparam logic [`UV_CNT_W-1:0] LAST = `UV_CNT_W'(LIMIT - 1);

    // ==========================================================
    // Comparator synchroniser
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q <= 1'h0;
            s2_q <= 1'h0;
            s3_q <= 1'h0;
            low_q <= 1'h0;
        end
        else
        begin
            s1_q <= supply_low;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                low_q <= s3_q;
        end
    end

    // ==========================================================
    // Detection timer, flag on expiry
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= '0;
            uv.flag_n <= `FLAG_N_RST;
        end
        else if (uv.restart || !low_q)
        begin
            cnt_q <= '0;
            uv.flag_n <= `FLAG_N_RST;
        end
        else if (uv.flag_n)
        begin
            cnt_q <= cnt_q + `UV_CNT_W'(1);
            if (cnt_q == LAST)
                uv.flag_n <= 1'h0;
        end
    end

    a_flag_on_expiry: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(uv.flag_n) |-> $past(cnt_q) == LAST && $past(low_q))
        else $error("undervoltage flag set before timer expiry");
endmodule // uv_flag_timer

/* undervoltage_recovery_mode_fsm.sv */
`timescale 1ns/1ns
`include "uvr_consts.svh"
module undervoltage_recovery_mode_fsm #(
    parameter int UV_DETECT_CYCLES = `UV_DETECT_CYCLES
)(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic standby_select_n_input,
    input wire logic enable_mode_input,
    input wire logic bus_data_input,
    input wire logic bus_active_input,
    input wire logic [2:0] supply_low,
    input wire logic wake_event,
    input wire logic wake_source_bit,
    input wire logic status_read,
    output logic error_n_output,
    output logic receive_data_output,
    output logic receive_active_output,
    output logic [`STATUS_W-1:0] status_info_register,
    output uvr_pkg::op_mode_e mode_state
);
    import uvr_pkg::*;

    op_mode_e mode_q, mode_d;
    logic [`PIN_NUM-1:0] p1_q, p2_q, p3_q, pin_q;
    logic [2:0] flag_n, flag_n_prev_q;
    logic wake_n_q, sleep_cause_n_q, cause_n_d, restart_q;
    logic wake_set, wake_clr, err_sel;
    logic uv_any, uv_hard, cmd_stby_n, cmd_en, recovered;
    logic [`STATUS_W-1:0] status_q;

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            p1_q <= '0;
            p2_q <= '0;
            p3_q <= '0;
            pin_q <= '0;
        end
        else
        begin
            p1_q <= {bus_active_input, bus_data_input, enable_mode_input, standby_select_n_input};
            p2_q <= p1_q;
            p3_q <= p2_q;
            for (int i = 0; i < `PIN_NUM; i++)
                if (p2_q[i] == p3_q[i])
                    pin_q[i] <= p3_q[i];
        end
    end

    assign cmd_stby_n = pin_q[`PIN_STBY_N];
    assign cmd_en = pin_q[`PIN_EN];

    // ==========================================================
    // Supply undervoltage flags
    uv_flag_if uv_if[3] ();

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_uv
            assign uv_if[g].restart = restart_q;
            assign flag_n[g] = uv_if[g].flag_n;
            uv_flag_timer #(.LIMIT(UV_DETECT_CYCLES)) u_timer (
                .core_clk(core_clk),
                .nrst(nrst),
                .supply_low(supply_low[g]),
                .uv(uv_if[g])
            );
        end
    endgenerate

    assign uv_any = ~&flag_n;
    assign uv_hard = !flag_n[`SUPPLY_BAT] || !flag_n[`SUPPLY_IO];
    assign recovered = ~&flag_n_prev_q && !uv_any;

    // ==========================================================
    // Mode decision
    assign wake_set = wake_event && wake_n_q && mode_q != full_operation_mode
        && mode_q != listen_only_mode;

    always_comb
    begin
        mode_d = mode_q;
        cause_n_d = sleep_cause_n_q;
        if (wake_set && (mode_q == low_power_sleep_mode || mode_q == sleep_request_mode))
            mode_d = standby_low_power_mode;
        else if (uv_hard)
        begin
            if (mode_q != low_power_sleep_mode)
            begin
                mode_d = low_power_sleep_mode;
                cause_n_d = 1'h0;
            end
        end
        else if (uv_any)
        begin
            if (mode_q != low_power_sleep_mode)
                mode_d = standby_low_power_mode;
        end
        else
        begin
            case ({cmd_stby_n, cmd_en})
                2'h3: mode_d = full_operation_mode;
                2'h2: mode_d = listen_only_mode;
                2'h0:
                begin
                    if (mode_q != low_power_sleep_mode || !sleep_cause_n_q)
                        mode_d = standby_low_power_mode;
                end
                2'h1:
                begin
                    if (mode_q == sleep_request_mode)
                    begin
                        mode_d = low_power_sleep_mode;
                        cause_n_d = 1'h1;
                    end
                    else if (mode_q != low_power_sleep_mode && wake_n_q)
                        mode_d = sleep_request_mode;
                end
                default: mode_d = mode_q;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_q <= standby_low_power_mode;
            sleep_cause_n_q <= `FLAG_N_RST;
            flag_n_prev_q <= '1;
        end
        else
        begin
            mode_q <= mode_d;
            sleep_cause_n_q <= cause_n_d;
            flag_n_prev_q <= flag_n;
        end
    end

    // ==========================================================
    // Wake flag: clears once normal mode is in force, or on a status read
    assign wake_clr = mode_q == full_operation_mode || status_read;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wake_n_q <= `FLAG_N_RST;
            restart_q <= 1'h0;
        end
        else
        begin
            if (wake_set)
                wake_n_q <= 1'h0;
            else if (wake_clr)
                wake_n_q <= 1'h1;
            restart_q <= wake_set;
        end
    end

    // ==========================================================
    // Status undervoltage bits
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            status_q <= `STATUS_RST;
        else
        begin
            if (wake_clr)
                status_q <= `STATUS_RST;
            if (!flag_n[`SUPPLY_BAT] || status_q[`STATUS_BIT_BAT] && !wake_clr)
                status_q[`STATUS_BIT_BAT] <= 1'h1;
            if (!flag_n[`SUPPLY_CORE] || status_q[`STATUS_BIT_CORE] && !wake_clr)
                status_q[`STATUS_BIT_CORE] <= 1'h1;
            if (!flag_n[`SUPPLY_IO] || status_q[`STATUS_BIT_IO] && !wake_clr)
                status_q[`STATUS_BIT_IO] <= 1'h1;
        end
    end

    assign err_sel = status_q[`STATUS_BIT_BAT] || status_q[`STATUS_BIT_CORE]
        || status_q[`STATUS_BIT_IO];

    // ==========================================================
    // Output pins
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            error_n_output <= `OUT_RST;
            receive_data_output <= `OUT_RST;
            receive_active_output <= `OUT_RST;
        end
        else if (!flag_n[`SUPPLY_IO])
        begin
            error_n_output <= 1'h0;
            receive_data_output <= 1'h0;
            receive_active_output <= 1'h0;
        end
        else
        begin
            case ({cmd_stby_n, cmd_en})
                2'h3: error_n_output <= !err_sel;
                2'h2: error_n_output <= !wake_source_bit;
                default: error_n_output <= wake_n_q;
            endcase
            if (mode_q == full_operation_mode || mode_q == listen_only_mode)
            begin
                receive_data_output <= pin_q[`PIN_BUS_DATA];
                receive_active_output <= pin_q[`PIN_BUS_ACT];
            end
            else
            begin
                receive_data_output <= wake_n_q;
                receive_active_output <= wake_n_q;
            end
        end
    end

    assign status_info_register = status_q;
    assign mode_state = mode_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_wake_clear_after: assert property (
        mode_q != full_operation_mode ##1 mode_q == full_operation_mode && !status_read
        |-> !$past(wake_set) || !wake_n_q ##1 wake_n_q)
        else $error("wake flag not cleared after normal entry");
    a_no_wake_normal: assert property (
        mode_q == full_operation_mode [*2] |-> wake_n_q)
        else $error("wake flag set in normal mode");
    a_uv_sleep_entry: assert property (
        uv_hard && !wake_set && mode_q != low_power_sleep_mode
        |=> mode_q == low_power_sleep_mode && !sleep_cause_n_q)
        else $error("undervoltage did not enter sleep");
    a_host_sleep_cause: assert property (
        mode_q == sleep_request_mode && !uv_hard ##1 mode_q == low_power_sleep_mode
        |-> sleep_cause_n_q)
        else $error("host sleep left cause flag low");
    a_sleep_recover: assert property (
        recovered && mode_q == low_power_sleep_mode && !wake_set && {cmd_stby_n, cmd_en} == 2'h3
        |=> mode_q == full_operation_mode)
        else $error("sleep recovery ignored normal command");
    a_standby_gate: assert property (
        mode_q == low_power_sleep_mode && !uv_any && !wake_set && sleep_cause_n_q
        && {cmd_stby_n, cmd_en} == 2'h0 |=> mode_q == low_power_sleep_mode)
        else $error("host sleep reached standby");
    a_gts_wake_block: assert property (
        mode_q == standby_low_power_mode && !uv_any && !wake_n_q && {cmd_stby_n, cmd_en} == 2'h1
        |=> mode_q == standby_low_power_mode)
        else $error("sleep request taken with wake flag set");
    a_err_by_cmd: assert property (
        flag_n[`SUPPLY_IO] && {cmd_stby_n, cmd_en} == 2'h3 |=> error_n_output == !$past(err_sel))
        else $error("error output ignores normal command");
    a_rx_follow: assert property (
        flag_n[`SUPPLY_IO] && mode_q == listen_only_mode
        |=> receive_data_output == $past(pin_q[`PIN_BUS_DATA]))
        else $error("receive data not following bus");
endmodule // undervoltage_recovery_mode_fsm

/* host_model.sv */
`timescale 1ns/1ns
module host_model (
    input wire logic core_clk,
    input wire logic [1:0] cmd,
    input wire logic bus_level,
    output logic standby_select_n_input,
    output logic enable_mode_input,
    output logic bus_data_input,
    output logic bus_active_input
);
    // Pins move after the falling edge and hold until the next command
    always @(negedge core_clk)
    begin
        {standby_select_n_input, enable_mode_input} <= cmd;
        bus_data_input <= bus_level;
        bus_active_input <= ~bus_level;
    end
endmodule // host_model

/* undervoltage_recovery_mode_fsm_bench.sv */
`timescale 1ns/1ns
`define CHECK_EQ(nm, e, a) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module undervoltage_recovery_mode_fsm_bench;
    import uvr_pkg::*;
    logic core_clk = 1'h0;
    logic nrst = 1'h0;
    logic [1:0] cmd = 2'h0;
    logic bus_level = 1'h1;
    logic [2:0] supply_low = 3'h0;
    logic wake_event = 1'h0;
    logic wake_source_bit = 1'h0;
    logic status_read = 1'h0;
    logic stby_n, en, bdat, bact, err_n, rxd, rx_act;
    logic [15:0] status_bits;
    op_mode_e mode;
    int miscompares = 0;
    int n_checks = 0;

    always #5 core_clk = ~core_clk;

    host_model i_host (.core_clk(core_clk), .cmd(cmd), .bus_level(bus_level),
        .standby_select_n_input(stby_n), .enable_mode_input(en),
        .bus_data_input(bdat), .bus_active_input(bact));

    undervoltage_recovery_mode_fsm #(.UV_DETECT_CYCLES(8)) i_dut (
        .core_clk(core_clk), .nrst(nrst), .standby_select_n_input(stby_n),
        .enable_mode_input(en), .bus_data_input(bdat), .bus_active_input(bact),
        .supply_low(supply_low), .wake_event(wake_event),
        .wake_source_bit(wake_source_bit), .status_read(status_read),
        .error_n_output(err_n), .receive_data_output(rxd),
        .receive_active_output(rx_act), .status_info_register(status_bits),
        .mode_state(mode));

    // ==========================================================
    // Helpers
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic wait_mode(input op_mode_e m);
        int i;
        i = 0;
        while (mode !== m && i < 100)
        begin
            @(negedge core_clk);
            i++;
        end
        `CHECK_EQ("mode", m, mode)
    endtask

    task automatic pulse_wake();
        wake_event = 1'h1;
        idle(1);
        wake_event = 1'h0;
    endtask

    task automatic complete_run();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        `CHECK_EQ("mode", standby_low_power_mode, mode)
        `CHECK_EQ("err_n", 1'h1, err_n)
        `CHECK_EQ("rx", 2'h3, {rxd, rx_act})
        `CHECK_EQ("status", 16'h0000, status_bits)
    endtask

    task automatic t_bat_recover_normal();
        supply_low = 3'h1;
        idle(4);
        supply_low = 3'h0;
        idle(20);
        `CHECK_EQ("mode", standby_low_power_mode, mode)
        supply_low = 3'h1;
        wait_mode(low_power_sleep_mode);
        `CHECK_EQ("status8", 1'h1, status_bits[8])
        cmd = 2'h3;
        idle(20);
        `CHECK_EQ("mode", low_power_sleep_mode, mode)
        supply_low = 3'h0;
        wait_mode(full_operation_mode);
        idle(3);
        `CHECK_EQ("err_n", 1'h1, err_n)
        `CHECK_EQ("status", 16'h0000, status_bits)
    endtask

    task automatic t_io_recover_standby();
        cmd = 2'h0;
        wait_mode(standby_low_power_mode);
        supply_low = 3'h2;
        wait_mode(low_power_sleep_mode);
        idle(2);
        `CHECK_EQ("outs", 3'h0, {err_n, rxd, rx_act})
        `CHECK_EQ("status10", 1'h1, status_bits[10])
        supply_low = 3'h0;
        wait_mode(standby_low_power_mode);
        status_read = 1'h1;
        idle(1);
        status_read = 1'h0;
        idle(2);
        `CHECK_EQ("status", 16'h0000, status_bits)
    endtask

    task automatic t_host_sleep_wake();
        cmd = 2'h1;
        wait_mode(low_power_sleep_mode);
        cmd = 2'h0;
        idle(20);
        `CHECK_EQ("mode", low_power_sleep_mode, mode)
        pulse_wake();
        wait_mode(standby_low_power_mode);
        idle(3);
        `CHECK_EQ("err_n", 1'h0, err_n)
        `CHECK_EQ("rxd", 1'h0, rxd)
        cmd = 2'h1;
        idle(20);
        `CHECK_EQ("mode", standby_low_power_mode, mode)
        `CHECK_EQ("err_n", 1'h0, err_n)
        cmd = 2'h3;
        wait_mode(full_operation_mode);
        idle(3);
        `CHECK_EQ("err_n", 1'h1, err_n)
        pulse_wake();
        idle(5);
        `CHECK_EQ("err_n", 1'h1, err_n)
        `CHECK_EQ("mode", full_operation_mode, mode)
    endtask

    task automatic t_core_recover();
        supply_low = 3'h4;
        wait_mode(standby_low_power_mode);
        `CHECK_EQ("status9", 1'h1, status_bits[9])
        cmd = 2'h2;
        supply_low = 3'h0;
        wait_mode(listen_only_mode);
    endtask

    task automatic t_listen_follow();
        wake_source_bit = 1'h1;
        idle(3);
        `CHECK_EQ("err_n", 1'h0, err_n)
        wake_source_bit = 1'h0;
        bus_level = 1'h0;
        idle(10);
        `CHECK_EQ("rxd", 1'h0, rxd)
        `CHECK_EQ("rx_act", 1'h1, rx_act)
        bus_level = 1'h1;
        idle(10);
        `CHECK_EQ("rxd", 1'h1, rxd)
        `CHECK_EQ("rx_act", 1'h0, rx_act)
        `CHECK_EQ("err_n", 1'h1, err_n)
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        idle(3);
        t_reset();
        nrst = 1'h1;
        idle(10);
        t_bat_recover_normal();
        t_io_recover_standby();
        t_host_sleep_wake();
        t_core_recover();
        t_listen_follow();
        complete_run();
    end

    initial
    begin
        #100000;
        miscompares++;
        complete_run();
    end
endmodule // undervoltage_recovery_mode_fsm_bench
